/* File: serial_flash_feature_regs.sv */
// Feature register bank of a serial NAND flash, reached by the host over the link.
`timescale 1ns/1ps
module serial_flash_feature_regs
  import flash_feature_pkg::*;
(
  input  wire logic                                     sys_clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     sclkPin,
  input  wire logic                                     csPin_n,
  input  wire logic                                     mosiPin,
  input  wire logic                                     writeGuardPin_n,
  input  wire logic                                     cmdResetPulse,
  input  wire logic                                     opBusy,
  input  wire logic                                     opDone,
  input  wire logic                                     opProgFail,
  input  wire logic                                     opEraseFail,
  input  wire logic                                     opReadDone,
  input  wire logic [3:0]                               opFlipCount,
  input  wire logic                                     opUncorrectable,
  input  wire logic                                     opCmdAccepted,
  input  wire logic [flash_feature_pkg::BLOCK_ADDR_W-1:0] opBlockAddr,
  output logic                                          misoPin,
  output logic                                          misoOe_n,
  output logic                                          lockRangeHit,
  output logic                                          idReadMode,
  output logic                                          eccEnable,
  output logic                                          protectEnable,
  output logic                                          fastReadEnable,
  output logic                                          holdDisable,
  output logic                                          writeLatch
);
  import flash_feature_pkg::*;

  // ************************************************************
  // Link and lock decode
  // ************************************************************
  link_bus_if lnk ();
  logic       misoRaw;
  logic       blockLocked;

  link_shifter u_shift (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sclkPin (sclkPin),
    .csPin_n (csPin_n),
    .mosiPin (mosiPin),
    .misoOut (misoRaw),
    .lnk     (lnk.shifter)
  );

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {S_OPCODE, S_SET_ADDR, S_SET_DATA, S_GET_ADDR, S_GET_STREAM,
                            S_IGNORE} phase_t;

  typedef struct packed {
    phase_t     phase;
    logic [7:0] addr;
    logic [7:0] lockCfg;
    logic [7:0] options;
    logic [7:0] threshold;
    logic       wlatch;
    logic       progFail;
    logic       eraseFail;
    logic [1:0] eccStat;
    logic       guardS1;
    logic       guardS2;
    logic       loadTx;
    logic [7:0] txByte;
    logic       miso;
    logic       misoOe_n;
    logic       locked;
  } bank_t;

  bank_t cur_q;
  bank_t nxt_d;

  lock_decoder u_lock (
    .range     (cur_q.lockCfg[LOCK_RANGE_LSB +: 3]),
    .blockAddr (opBlockAddr),
    .locked    (blockLocked)
  );

  // Readback of an address, reserved bits forced to zero; status is built live.
  function automatic logic [7:0] readback(input bank_t s, input logic [7:0] a, input logic busy);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      LOCK_CFG_ADDR:  v = s.lockCfg & LOCK_CFG_MASK;
      OPTIONS_ADDR:   v = s.options & OPTIONS_MASK;
      THRESHOLD_ADDR: v = s.threshold & THRESHOLD_MASK;
      STATUS_ADDR: begin
        v[ECC_STAT_LSB +: 2] = s.eccStat;
        v[PROG_FAIL_BIT]     = s.progFail;
        v[ERASE_FAIL_BIT]    = s.eraseFail;
        v[WLATCH_BIT]        = s.wlatch;
        v[BUSY_BIT]          = busy;
      end
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_d         = cur_q;
    nxt_d.loadTx  = 1'b0;
    nxt_d.guardS1 = writeGuardPin_n;
    nxt_d.guardS2 = cur_q.guardS1;
    nxt_d.miso    = misoRaw;
    nxt_d.locked  = blockLocked;

    // Fail flags clear when the next command is taken; an outcome reported
    // in the same cycle wins so a failure is never lost.
    if (opCmdAccepted) begin
      nxt_d.progFail  = 1'b0;
      nxt_d.eraseFail = 1'b0;
    end
    if (opDone) begin
      nxt_d.progFail  = opProgFail;
      nxt_d.eraseFail = opEraseFail;
    end
    if (opReadDone) begin
      if (!cur_q.options[ECC_EN_BIT] || opFlipCount == 4'h0) begin
        nxt_d.eccStat = ECC_CLEAN;
      end else if (opUncorrectable) begin
        nxt_d.eccStat = ECC_FAILED;
      end else if (opFlipCount >= cur_q.threshold[7:4]) begin
        nxt_d.eccStat = ECC_FIXED_HIGH;
      end else begin
        nxt_d.eccStat = ECC_FIXED_LOW;
      end
    end

    if (!lnk.frameActive) begin
      nxt_d.phase    = S_OPCODE;
      nxt_d.misoOe_n = 1'b1;
    end else if (lnk.byteValid) begin
      case (cur_q.phase)
        S_OPCODE: begin
          case (lnk.rxByte)
            OP_SET_FEATURE: nxt_d.phase = S_SET_ADDR;
            OP_GET_FEATURE: nxt_d.phase = S_GET_ADDR;
            OP_WRITE_EN: begin
              nxt_d.wlatch = 1'b1;
              nxt_d.phase  = S_IGNORE;
            end
            OP_WRITE_DIS: begin
              nxt_d.wlatch = 1'b0;
              nxt_d.phase  = S_IGNORE;
            end
            default: nxt_d.phase = S_IGNORE;
          endcase
        end
        S_SET_ADDR: begin
          nxt_d.addr  = lnk.rxByte;
          nxt_d.phase = S_SET_DATA;
        end
        S_SET_DATA: begin
          nxt_d.phase = S_IGNORE;
          case (cur_q.addr)
            LOCK_CFG_ADDR: begin
              if (!(cur_q.lockCfg[LOCK_WD_BIT] && !cur_q.guardS2)) begin
                nxt_d.lockCfg = lnk.rxByte & LOCK_CFG_MASK;
              end
            end
            OPTIONS_ADDR:   nxt_d.options   = lnk.rxByte & OPTIONS_MASK;
            THRESHOLD_ADDR: nxt_d.threshold = lnk.rxByte & THRESHOLD_MASK;
            default:        nxt_d.phase     = S_IGNORE;
          endcase
        end
        S_GET_ADDR: begin
          nxt_d.addr     = lnk.rxByte;
          nxt_d.phase    = S_GET_STREAM;
          nxt_d.misoOe_n = 1'b0;
          nxt_d.loadTx   = 1'b1;
          nxt_d.txByte   = readback(cur_q, lnk.rxByte, opBusy);
        end
        S_GET_STREAM: begin
          // Reload each byte boundary so busy and fail bits are fresh.
          nxt_d.loadTx = 1'b1;
          nxt_d.txByte = readback(cur_q, cur_q.addr, opBusy);
        end
        S_IGNORE: nxt_d.phase = S_IGNORE;
        default:  nxt_d.phase = S_IGNORE;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // The reset input is the power-on reset; a reset command only aborts the
  // array operation outside, so it leaves the settings here alone.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_q           <= '0;
      cur_q.phase     <= S_OPCODE;
      cur_q.lockCfg   <= LOCK_CFG_RESET;
      cur_q.options   <= OPTIONS_RESET;
      cur_q.threshold <= THRESHOLD_RESET;
      cur_q.misoOe_n  <= 1'b1;
      cur_q.guardS1   <= 1'b1;
      cur_q.guardS2   <= 1'b1;
      cur_q.locked    <= 1'b1;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign misoPin        = cur_q.miso;
  assign misoOe_n       = cur_q.misoOe_n;
  assign lockRangeHit   = cur_q.locked;
  assign idReadMode     = cur_q.options[ID_READ_BIT];
  assign eccEnable      = cur_q.options[ECC_EN_BIT];
  assign protectEnable  = cur_q.options[PROTECT_EN_BIT];
  assign fastReadEnable = cur_q.options[FAST_READ_BIT];
  assign holdDisable    = cur_q.options[HOLD_DIS_BIT];
  assign writeLatch     = cur_q.wlatch;
  assign lnk.loadTx     = cur_q.loadTx;
  assign lnk.txByte     = cur_q.txByte;

  // ************************************************************
  // Checks
  // ************************************************************
  a_guard_blocks_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.lockCfg[LOCK_WD_BIT] && !cur_q.guardS2) |=> $stable(cur_q.lockCfg))
    else $error("lock register changed while guarded");
  a_latch_only_cmds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(cur_q.wlatch) |-> $past(cur_q.phase) == S_OPCODE && $past(lnk.byteValid))
    else $error("write latch changed outside its commands");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.lockCfg & ~LOCK_CFG_MASK) == 8'h00 && (cur_q.options & ~OPTIONS_MASK) == 8'h00)
    else $error("reserved bit set");
  a_fail_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.progFail && !opCmdAccepted && !opDone) |=> cur_q.progFail)
    else $error("program fail dropped early");
  a_fail_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($changed(cur_q.progFail) || $changed(cur_q.eraseFail))
    |-> ($past(opDone) || $past(opCmdAccepted)))
    else $error("fail flag moved without an operation result");
  a_ecc_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (opReadDone && eccEnable && !opUncorrectable && opFlipCount != 4'h0
     && opFlipCount >= cur_q.threshold[7:4]) |=> cur_q.eccStat == ECC_FIXED_HIGH)
    else $error("wrong correction status");
  a_ecc_failed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (opReadDone && eccEnable && opUncorrectable && opFlipCount != 4'h0)
    |=> cur_q.eccStat == ECC_FAILED)
    else $error("uncorrectable read not reported");
  a_option_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.phase == S_SET_DATA && lnk.frameActive && lnk.byteValid && cur_q.addr == OPTIONS_ADDR)
    |=> cur_q.options == ($past(lnk.rxByte) & OPTIONS_MASK))
    else $error("option write not applied");
  a_reset_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmdResetPulse && !lnk.byteValid) |=> $stable(cur_q.options) && $stable(cur_q.lockCfg))
    else $error("settings changed by a reset command");
  a_stream_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.phase == S_GET_STREAM && lnk.byteValid && lnk.frameActive) |=> cur_q.loadTx)
    else $error("stream byte not reloaded");
  a_busy_shown: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_q.phase == S_GET_STREAM && cur_q.addr == STATUS_ADDR && lnk.byteValid)
    |=> cur_q.txByte[BUSY_BIT] == $past(opBusy))
    else $error("status byte busy bit stale");
  a_oe_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lnk.frameActive |=> misoOe_n)
    else $error("output driven outside a frame");
  a_oe_stream: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur_q.phase == S_GET_STREAM |-> !misoOe_n)
    else $error("output idle during a feature read");
  c_set_feature: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cur_q.phase == S_SET_DATA ##1 cur_q.phase == S_IGNORE);
  c_status_poll: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cur_q.phase == S_GET_STREAM && opBusy ##1 !opBusy);
  c_guarded: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cur_q.lockCfg[LOCK_WD_BIT] && !cur_q.guardS2);

endmodule

/* File: flash_feature_pkg.sv */
// Package with the feature map, field positions, reset values and opcodes.
package flash_feature_pkg;

  // ************************************************************
  // Feature addresses
  // ************************************************************
  localparam logic [7:0] LOCK_CFG_ADDR   = 8'ha0;
  localparam logic [7:0] OPTIONS_ADDR    = 8'hb0;
  localparam logic [7:0] STATUS_ADDR     = 8'hc0;
  localparam logic [7:0] THRESHOLD_ADDR  = 8'h10;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_SET_FEATURE  = 8'h1f;
  localparam logic [7:0] OP_GET_FEATURE  = 8'h0f;
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LOCK_WD_BIT     = 7;
  localparam int LOCK_RANGE_LSB  = 3;
  localparam int ID_READ_BIT     = 6;
  localparam int ECC_EN_BIT      = 4;
  localparam int PROTECT_EN_BIT  = 2;
  localparam int FAST_READ_BIT   = 1;
  localparam int HOLD_DIS_BIT    = 0;
  localparam int ECC_STAT_LSB    = 4;
  localparam int PROG_FAIL_BIT   = 3;
  localparam int ERASE_FAIL_BIT  = 2;
  localparam int WLATCH_BIT      = 1;
  localparam int BUSY_BIT        = 0;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [7:0] LOCK_CFG_MASK   = 8'hb8;
  localparam logic [7:0] OPTIONS_MASK    = 8'h57;
  localparam logic [7:0] THRESHOLD_MASK  = 8'hf0;
  localparam logic [7:0] LOCK_CFG_RESET  = 8'h38;
  localparam logic [7:0] OPTIONS_RESET   = 8'h12;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;

  // ************************************************************
  // Lock range and correction status codes
  // ************************************************************
  localparam logic [2:0] RANGE_NONE      = 3'h0;
  localparam logic [2:0] RANGE_ALL       = 3'h7;
  localparam logic [1:0] ECC_CLEAN       = 2'h0;
  localparam logic [1:0] ECC_FIXED_LOW   = 2'h1;
  localparam logic [1:0] ECC_FAILED      = 2'h2;
  localparam logic [1:0] ECC_FIXED_HIGH  = 2'h3;

  localparam int BLOCK_ADDR_W = 11;

endpackage

/* File: link_bus_if.sv */
// Interface carrying decoded link bytes from the shifter to the register bank.
`timescale 1ns/1ps
interface link_bus_if;
  logic       frameActive;
  logic       frameStart;
  logic       byteValid;
  logic [7:0] rxByte;
  logic       loadTx;
  logic [7:0] txByte;

  modport shifter (output frameActive, output frameStart, output byteValid, output rxByte,
                   input loadTx, input txByte);
  modport bank (input frameActive, input frameStart, input byteValid, input rxByte,
                output loadTx, output txByte);
endinterface

/* File: link_shifter.sv */
// Serial link shifter: synchronises the host pins and moves bytes MSB first.
`timescale 1ns/1ps
module link_shifter
  import flash_feature_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sclkPin,
  input  wire logic csPin_n,
  input  wire logic mosiPin,
  output logic      misoOut,
  link_bus_if.shifter lnk
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [1:0] sclkSync;
    logic [1:0] csSync;
    logic [1:0] mosiSync;
    logic       sclkLast;
    logic [2:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic       frame;
    logic       start;
    logic       valid;
    logic [7:0] rxByte;
    logic       miso;
  } shift_t;

  shift_t cur_q;
  shift_t nxt_d;
  logic   rise;
  logic   fall;

  always_comb begin
    nxt_d = cur_q;
    nxt_d.sclkSync = {cur_q.sclkSync[0], sclkPin};
    nxt_d.csSync   = {cur_q.csSync[0], csPin_n};
    nxt_d.mosiSync = {cur_q.mosiSync[0], mosiPin};
    nxt_d.sclkLast = cur_q.sclkSync[1];
    rise = cur_q.sclkSync[1] & ~cur_q.sclkLast;
    fall = ~cur_q.sclkSync[1] & cur_q.sclkLast;
    nxt_d.start = 1'b0;
    nxt_d.valid = 1'b0;
    if (cur_q.csSync[1]) begin
      nxt_d.frame  = 1'b0;
      nxt_d.bitCnt = 3'h0;
    end else begin
      if (!cur_q.frame) begin
        nxt_d.frame = 1'b1;
        nxt_d.start = 1'b1;
      end
      // Data is taken on the rising edge and launched on the falling edge.
      if (rise) begin
        nxt_d.rxShift = {cur_q.rxShift[6:0], cur_q.mosiSync[1]};
        nxt_d.bitCnt  = cur_q.bitCnt + 3'h1;
        if (cur_q.bitCnt == 3'h7) begin
          nxt_d.valid  = 1'b1;
          nxt_d.rxByte = {cur_q.rxShift[6:0], cur_q.mosiSync[1]};
        end
      end
      if (fall) begin
        nxt_d.miso    = cur_q.txShift[7];
        nxt_d.txShift = {cur_q.txShift[6:0], 1'b0};
      end
    end
    if (lnk.loadTx) begin
      nxt_d.txShift = lnk.txByte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign lnk.frameActive = cur_q.frame;
  assign lnk.frameStart  = cur_q.start;
  assign lnk.byteValid   = cur_q.valid;
  assign lnk.rxByte      = cur_q.rxByte;
  assign misoOut         = cur_q.miso;

endmodule

/* File: lock_decoder.sv */
// Lock range decoder: tells whether a block falls in the locked upper region.
`timescale 1ns/1ps
module lock_decoder
  import flash_feature_pkg::*;
(
  input  wire logic [2:0]              range,
  input  wire logic [BLOCK_ADDR_W-1:0] blockAddr,
  output logic                         locked
);

  // ************************************************************
  // Decode
  // ************************************************************
  // Codes 1..6 lock the upper 1/64 .. 1/2, so the top (7-code) address bits
  // must all be ones; zero unlocks everything and seven locks everything.
  always_comb begin
    locked = 1'b0;
    case (range)
      RANGE_NONE: locked = 1'b0;
      RANGE_ALL:  locked = 1'b1;
      3'h1:       locked = &blockAddr[10:5];
      3'h2:       locked = &blockAddr[10:6];
      3'h3:       locked = &blockAddr[10:7];
      3'h4:       locked = &blockAddr[10:8];
      3'h5:       locked = &blockAddr[10:9];
      3'h6:       locked = blockAddr[10];
      default:    locked = 1'b1;
    endcase
  end

endmodule

/* File: host_link_model.sv */
// Host controller model that frames feature commands on the serial link.
`timescale 1ns/1ps
module host_link_model (
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] rxQ[$];
  initial begin
    sclk = 0;
    csN = 1;
    mosi = 0;
  end
  // The clock rests low between frames; a released data line flips so stale bits show.
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                       input int nTx, input int nRd);
    logic [7:0] r;
    logic [7:0] t;
    rxQ.delete();
    csN = 0;
    #125;
    for (int k = 0; k < nTx + nRd; k++) begin
      t = k == 0 ? b0 : k == 1 ? b1 : b2;
      for (int i = 7; i >= 0; i--) begin
        mosi = t[i];
        #62.5 sclk = 1;
        r[i] = miso;
        #62.5 sclk = 0;
      end
      if (k >= nTx) rxQ.push_back(r);
    end
    #62.5 csN = 1;
    mosi = ~mosi;
    #250;
  endtask
endmodule

/* File: test_serial_flash_feature_regs.sv */
// Self-checking bench for the feature register bank.
`timescale 1ns/1ps
module test_serial_flash_feature_regs;
  import flash_feature_pkg::*;
  logic sys_clk = 0, rst_n = 0, gN = 1, rc = 0, bz = 0, dn = 0, pF = 0, eF = 0, rd = 0;
  logic un = 0, ac = 0, sclk, csN, mosi, miso, oe, hit, idm, ecE, prE, frE, hdD, wlP;
  logic [3:0]  fc = 0;
  logic [10:0] blk = 0;
  localparam int P_AC = 0, P_DN = 1, P_RD = 2, P_RC = 3;
  wire         mLine = oe ? 1'bz : miso;
  int errCount = 0, checksDone = 0, cyc = 0, lockQ = 8'h38, optQ = 8'h12, thrQ = 0;
  int ecc = 0, pf = 0, ef = 0, wl = 0, bsy = 0;
  always #5 sys_clk = ~sys_clk;
  serial_flash_feature_regs serial_flash_feature_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclkPin(sclk), .csPin_n(csN), .mosiPin(mosi), .writeGuardPin_n(gN), .cmdResetPulse(rc),
    .opBusy(bz), .opDone(dn), .opProgFail(pF), .opEraseFail(eF), .opReadDone(rd),
    .opFlipCount(fc), .opUncorrectable(un), .opCmdAccepted(ac), .opBlockAddr(blk),
    .misoPin(miso), .misoOe_n(oe), .lockRangeHit(hit), .idReadMode(idm), .eccEnable(ecE),
    .protectEnable(prE), .fastReadEnable(frE), .holdDisable(hdD), .writeLatch(wlP));
  host_link_model host_link_model_inst (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(mLine));
  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic endSim();
    $display("mismatches %0d comparisons %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The ceiling is about three times the expected run, so a stuck link cannot hang the bench.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errCount++;
      endSim();
    end
  end
  task automatic chkByte(string nm, logic [7:0] e, logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkLvl(string nm, logic e, logic g);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One-cycle strobe; the code picks which of the four event lines rises.
  task automatic pulse(input int w);
    @(negedge sys_clk) {rc, rd, dn, ac} = 4'(1 << w);
    @(negedge sys_clk) {rc, rd, dn, ac} = 4'h0;
  endtask
  function automatic logic [7:0] expB(logic [7:0] a);
    if (a == LOCK_CFG_ADDR) return lockQ[7:0];
    if (a == OPTIONS_ADDR) return optQ[7:0];
    if (a == THRESHOLD_ADDR) return {thrQ[3:0], 4'h0};
    return {2'b00, ecc[1:0], pf[0], ef[0], wl[0], bsy[0]};
  endfunction
  task automatic getChk(logic [7:0] a, int n);
    host_link_model_inst.frame(OP_GET_FEATURE, a, 8'h00, 2, n);
    foreach (host_link_model_inst.rxQ[i])
      chkByte("feature byte", expB(a), host_link_model_inst.rxQ[i]);
  endtask
  task automatic setF(logic [7:0] a, logic [7:0] d);
    host_link_model_inst.frame(OP_SET_FEATURE, a, d, 3, 0);
    if (a == LOCK_CFG_ADDR && !(lockQ[7] && !gN)) lockQ = d & LOCK_CFG_MASK;
    if (a == OPTIONS_ADDR) optQ = d & OPTIONS_MASK;
    if (a == THRESHOLD_ADDR) thrQ = d[7:4];
  endtask
  initial begin
    int r;
    int v;
    v = $urandom(31);
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    repeat (3) @(negedge sys_clk);
    getChk(LOCK_CFG_ADDR, 2);
    getChk(OPTIONS_ADDR, 2);
    getChk(STATUS_ADDR, 2);
    v = $urandom;
    setF(OPTIONS_ADDR, v[7:0]);
    pulse(P_RC);
    getChk(OPTIONS_ADDR, 1);
    chkLvl("idReadMode", optQ[6], idm);
    chkLvl("eccEnable", optQ[4], ecE);
    chkLvl("protectEnable", optQ[2], prE);
    chkLvl("fastReadEnable", optQ[1], frE);
    chkLvl("holdDisable", optQ[0], hdD);
    for (r = 0; r < 8; r++) begin
      blk = 11'(2048 - (2048 >> (7 - r)) - (r & 1));
      setF(LOCK_CFG_ADDR, 8'(r << 3));
      @(negedge sys_clk);
      chkLvl("lockRangeHit", r == 7 || (r != 0 && blk >= 2048 - (2048 >> (7 - r))), hit);
    end
    setF(LOCK_CFG_ADDR, 8'h88);
    @(negedge sys_clk) gN = 0;
    setF(LOCK_CFG_ADDR, 8'h00);
    getChk(LOCK_CFG_ADDR, 1);
    @(negedge sys_clk) gN = 1;
    setF(LOCK_CFG_ADDR, 8'h00);
    getChk(LOCK_CFG_ADDR, 1);
    host_link_model_inst.frame(OP_WRITE_EN, 8'h00, 8'h00, 1, 0);
    wl = 1;
    setF(STATUS_ADDR, 8'h00);
    getChk(STATUS_ADDR, 1);
    chkLvl("writeLatch", 1'b1, wlP);
    host_link_model_inst.frame(OP_WRITE_DIS, 8'h00, 8'h00, 1, 0);
    wl = 0;
    getChk(STATUS_ADDR, 1);
    setF(OPTIONS_ADDR, OPTIONS_RESET);
    setF(THRESHOLD_ADDR, 8'h50);
    getChk(THRESHOLD_ADDR, 1);
    for (r = 0; r < 5; r++) begin
      @(negedge sys_clk) fc = 4'(r * 2 + r / 2);
      un = (r == 4);
      pulse(P_RD);
      ecc = !optQ[4] ? 0 : un ? 2 : fc == 0 ? 0 : fc < thrQ ? 1 : 3;
      getChk(STATUS_ADDR, 1);
    end
    @(negedge sys_clk) bz = 1;
    bsy = 1;
    fork
      host_link_model_inst.frame(OP_GET_FEATURE, STATUS_ADDR, 8'h00, 2, 4);
      begin
        #3500 @(negedge sys_clk) bz = 0;
        pF = 1;
        pulse(P_DN);
      end
    join
    chkByte("busy byte", expB(STATUS_ADDR), host_link_model_inst.rxQ[0]);
    bsy = 0;
    pf = 1;
    chkByte("fresh byte", expB(STATUS_ADDR), host_link_model_inst.rxQ[3]);
    pF = 0;
    eF = 1;
    pulse(P_AC);
    pulse(P_DN);
    pf = 0;
    ef = 1;
    getChk(STATUS_ADDR, 2);
    pulse(P_AC);
    ef = 0;
    getChk(STATUS_ADDR, 1);
    endSim();
  end
endmodule
